// file: dv/stack_mem_model.sv
// partner model: stack ram that answers the register file's stack bus
module stack_mem_model
    import cpu_regs_pkg::*;
(
    input  wire logic       i_clk,
    input  wire stack_bus_s i_bus,
    output logic      [7:0] o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    initial o_rdata = 8'h00;
    always @(posedge i_clk) begin
        if (i_bus.valid && i_bus.write) begin
            mem[i_bus.addr[7:0]] <= i_bus.wdata;
        end
        // outside a read the byte inverts every cycle, so the stale byte shows again every other cycle
        if (i_bus.valid && !i_bus.write) begin
            o_rdata <= mem[i_bus.addr[7:0]];
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule

// file: dv/test_cpu_register_file_stack.sv
// testbench: registers, stack pushes and pulls, flags and interrupt mask
module test_cpu_register_file_stack;
    import cpu_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_nrst = 0, vld = 0, eirq = 0, tirq = 0;
    logic last_ext = 0;
    logic rd = 0, wr = 0, rdy, take, is_ext;
    logic [4:0] adr = 0;
    logic [3:0] be = 4'hf;
    logic [31:0] wd = 0, rdata;
    logic [7:0] srd;
    logic [12:0] pc;
    logic wt;
    core_req_s req = '0;
    stack_bus_s sbus;
    int n_mismatch = 0, n_compared = 0, cyc = 0, n_take = 0;
    logic [31:0] r, p;

    cpu_register_file_stack dut_u (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_req(req), .i_req_valid(vld), .o_req_ready(rdy), .o_stack(sbus),
        .i_stack_rdata(srd), .i_ext_irq(eirq), .i_timer_irq(tirq),
        .o_irq_take(take), .o_irq_is_ext(is_ext), .o_pc(pc),
        .i_pc_load(1'b0), .i_pc_value(13'h0000), .i_avs_address(adr),
        .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
        .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wt));
    stack_mem_model mem_u (.i_clk(i_clk), .i_bus(sbus), .o_rdata(srd));

    initial forever #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (take) n_take <= n_take + 1;
        if (take) last_ext <= is_ext;
        if (cyc == 5000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic avs(input logic w, input logic [4:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        do @(posedge i_clk); while (wt !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic op(input cpu_op_e o, input logic [7:0] v);
        req <= '{op: o, dst_index: 1'b0, operand: v, bit_val: 1'b0,
                 ret_addr: 13'h0abc};
        vld <= 1'b1;
        do @(posedge i_clk); while (!(rdy === 1'b1 && take === 1'b0));
        vld <= 1'b0;
        do @(posedge i_clk); while (rdy !== 1'b1);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        avs(0, OFF_SP, 0, r); chk(r, 32'hff);
        avs(1, OFF_ACC, 32'h1a5, r);
        avs(0, OFF_ACC, 0, r); chk(r, 32'ha5);
        be <= 4'h0;
        avs(1, OFF_ACC, 32'h11, r);
        be <= 4'hf;
        avs(0, OFF_ACC, 0, r); chk(r, 32'ha5);
        avs(1, OFF_INDEX, 32'h15a, r);
        avs(0, OFF_INDEX, 0, r); chk(r, 32'h5a);
        avs(1, OFF_PC, 32'hfffffe34, r);
        avs(0, OFF_PC, 0, r); chk(r, 32'h1e34);
        avs(0, 5'h18, 0, r); chk(r, 32'h0);
    endtask
    task automatic t_alu();
        avs(1, OFF_ACC, 32'h01, r);
        op(OP_ADD, 8'h0f);
        avs(0, OFF_ACC, 0, r); chk(r, 32'h10);
        avs(0, OFF_FLAGS, 0, r); chk(r & 32'h17, 32'h10);
        op(OP_ADD, 8'hf0);
        avs(0, OFF_FLAGS, 0, r); chk(r & 32'h17, 32'h03);
        op(OP_SUB, 8'h01);
        avs(0, OFF_FLAGS, 0, r); chk(r & 32'h07, 32'h05);
        op(OP_ADC, 8'h00);
        avs(0, OFF_FLAGS, 0, r); chk(r & 32'h17, 32'h13);
        op(OP_LOAD, 8'h81);
        avs(0, OFF_FLAGS, 0, r); chk(r & 32'h07, 32'h05);
        op(OP_ROL, 8'h00);
        avs(0, OFF_ACC, 0, r); chk(r, 32'h03);
        avs(0, OFF_FLAGS, 0, r); chk(r & 32'h07, 32'h01);
        op(OP_AND, 8'h04);
        avs(0, OFF_FLAGS, 0, r); chk(r & 32'h07, 32'h03);
    endtask
    task automatic t_call_ret();
        avs(0, OFF_PC, 0, p);
        op(OP_CALL, 8'h00);
        chk(mem_u.mem[8'hff], p[7:0]);
        chk(mem_u.mem[8'hfe] & 8'h1f, p[12:8]);
        avs(0, OFF_SP, 0, r); chk(r, 32'hfd);
        op(OP_RET, 8'h00);
        avs(0, OFF_SP, 0, r); chk(r, 32'hff);
        avs(0, OFF_PC, 0, r); chk(r, p);
    endtask
    task automatic t_wrap();
        avs(1, OFF_SP, 32'hc0, r);
        avs(0, OFF_PC, 0, p);
        op(OP_CALL, 8'h00);
        chk(mem_u.mem[8'hc0], p[7:0]);
        chk(mem_u.mem[8'hff] & 8'h1f, p[12:8]);
        avs(0, OFF_SP, 0, r); chk(r & 32'h3f, 32'h3e);
        op(OP_RSP, 8'h00);
        avs(0, OFF_SP, 0, r); chk(r, 32'hff);
    endtask
    task automatic t_irq();
        int n0;
        n0 = n_take;
        eirq <= 1'b1;
        tirq <= 1'b1;
        @(posedge i_clk);
        eirq <= 1'b0;
        tirq <= 1'b0;
        repeat (6) @(posedge i_clk);
        chk(n_take, n0);
        avs(0, OFF_PENDING, 0, r); chk(r != 0, 1);
        avs(0, OFF_PC, 0, p);
        avs(0, OFF_ACC, 0, r);
        op(OP_CLI, 8'h00);
        while (n_take == n0) @(posedge i_clk);
        chk(last_ext, 1'b1);
        do @(posedge i_clk); while (rdy !== 1'b1);
        chk(mem_u.mem[8'hfc], r[7:0]);
        chk(mem_u.mem[8'hff], p[7:0]);
        avs(0, OFF_SP, 0, r); chk(r, 32'hfa);
        avs(0, OFF_FLAGS, 0, r); chk(r & 32'h08, 32'h08);
    endtask

    task automatic report_and_stop();
        $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        t_regs();
        t_alu();
        t_call_ret();
        t_wrap();
        t_irq();
        report_and_stop();
    end
endmodule

// file: src/cpu_alu.sv
// combinational alu producing result and flag updates
module cpu_alu
    import cpu_regs_pkg::*;
(
    input  wire cpu_op_e    i_op,
    input  wire logic [7:0] i_a,
    input  wire logic [7:0] i_b,
    input  wire logic       i_carry,
    input  wire logic       i_bit_val,
    output logic      [7:0] o_result,
    output logic            o_carry,
    output logic            o_half,
    output logic            o_upd_carry,
    output logic            o_upd_half,
    output logic            o_upd_nz
);
    logic [8:0] sum;
    logic [4:0] nib;

    always_comb begin
        sum         = 9'h000;
        nib         = 5'h00;
        o_result    = i_a;
        o_carry     = i_carry;
        o_half      = 1'b0;
        o_upd_carry = 1'b0;
        o_upd_half  = 1'b0;
        o_upd_nz    = 1'b0;
        case (i_op)
            OP_ADD, OP_ADC: begin
                sum = {1'b0, i_a} + {1'b0, i_b}
                    + {8'h00, (i_op == OP_ADC) & i_carry};
                nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]}
                    + {4'h0, (i_op == OP_ADC) & i_carry};
                o_result    = sum[7:0];
                o_carry     = sum[8];
                o_half      = nib[4];
                o_upd_carry = 1'b1;
                o_upd_half  = 1'b1;
                o_upd_nz    = 1'b1;
            end
            OP_SUB: begin
                sum = {1'b0, i_a} - {1'b0, i_b};
                o_result    = sum[7:0];
                o_carry     = sum[8];
                o_upd_carry = 1'b1;
                o_upd_nz    = 1'b1;
            end
            OP_AND: begin
                o_result = i_a & i_b;
                o_upd_nz = 1'b1;
            end
            OP_LOAD: begin
                o_result = i_b;
                o_upd_nz = 1'b1;
            end
            OP_SHL, OP_ROL: begin
                o_result    = {i_a[6:0], (i_op == OP_ROL) & i_carry};
                o_carry     = i_a[7];
                o_upd_carry = 1'b1;
                o_upd_nz    = 1'b1;
            end
            OP_BTST: begin
                o_carry     = i_bit_val;
                o_upd_carry = 1'b1;
            end
            default: begin
                o_result = i_a;
            end
        endcase
    end
endmodule

// file: src/cpu_irq_latch.sv
// latch that holds one interrupt request until it is serviced
module cpu_irq_latch (
    input  wire logic i_clk,
    input  wire logic i_nrst,
    input  wire logic i_req,
    input  wire logic i_clear,
    output logic      o_pending
);
    logic pending_reg;

    // set wins over clear so a request in the service cycle is kept
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pending_reg <= 1'b0;
        end else if (i_req) begin
            pending_reg <= 1'b1;
        end else if (i_clear) begin
            pending_reg <= 1'b0;
        end
    end

    assign o_pending = pending_reg;
endmodule

// file: src/cpu_register_file_stack.sv
// cpu register file, stack sequencer and avalon register access
module cpu_register_file_stack
    import cpu_regs_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    input  wire core_req_s   i_req,
    input  wire logic        i_req_valid,
    output logic             o_req_ready,
    output stack_bus_s       o_stack,
    input  wire logic [7:0]  i_stack_rdata,
    input  wire logic        i_ext_irq,
    input  wire logic        i_timer_irq,
    output logic             o_irq_take,
    output logic             o_irq_is_ext,
    output logic [12:0]      o_pc,
    input  wire logic        i_pc_load,
    input  wire logic [12:0] i_pc_value,
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    input  wire logic [3:0]  i_avs_byteenable,
    output logic [31:0]      o_avs_readdata,
    output logic             o_avs_waitrequest
);
    // ****************************************
    // state
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PUSH,
        ST_PULL_ADDR,
        ST_PULL_DATA
    } seq_e;

    seq_e        seq_reg;
    logic [7:0]  acc_reg;
    logic [7:0]  index_reg;
    logic [12:0] pc_reg;
    logic [7:0]  sp_reg;
    logic [4:0]  flags_reg;
    logic [2:0]  cnt_reg;
    logic        is_rti_reg;
    logic [7:0]  pull_buf_reg [0:4];
    logic        avs_done_reg;

    logic [7:0] alu_res;
    logic       alu_c, alu_h, upd_c, upd_h, upd_nz;
    logic       ext_pend, tmr_pend;
    logic       take;
    logic       avs_hit;
    logic [7:0] push_byte;
    logic [2:0] push_len;
    logic [5:0] sp_low_up;

    cpu_alu u_alu (
        .i_op        (i_req.op),
        .i_a         (i_req.dst_index ? index_reg : acc_reg),
        .i_b         (i_req.operand),
        .i_carry     (flags_reg[FLAG_C]),
        .i_bit_val   (i_req.bit_val),
        .o_result    (alu_res),
        .o_carry     (alu_c),
        .o_half      (alu_h),
        .o_upd_carry (upd_c),
        .o_upd_half  (upd_h),
        .o_upd_nz    (upd_nz)
    );

    // ****************************************
    // interrupt request latches
    // ****************************************
    cpu_irq_latch u_ext (
        .i_clk     (i_clk),
        .i_nrst    (i_nrst),
        .i_req     (i_ext_irq),
        .i_clear   (take & ext_pend),
        .o_pending (ext_pend)
    );

    cpu_irq_latch u_tmr (
        .i_clk     (i_clk),
        .i_nrst    (i_nrst),
        .i_req     (i_timer_irq),
        .i_clear   (take & ~ext_pend & tmr_pend),
        .o_pending (tmr_pend)
    );

    // external first; nothing leaves the latch while the mask is set
    assign take = (seq_reg == ST_IDLE) & ~flags_reg[FLAG_I]
                & (ext_pend | tmr_pend) & ~i_req_valid;
    assign o_irq_take   = take;
    assign o_irq_is_ext = ext_pend;
    assign o_req_ready  = (seq_reg == ST_IDLE);
    assign o_pc         = pc_reg;

    // ****************************************
    // stack addressing
    // ****************************************
    assign sp_low_up = sp_reg[5:0] + 6'h01;
    assign push_len  = is_rti_reg ? 3'd5 : 3'd2;

    // push order: ret low, ret high, index, acc, flags
    always_comb begin
        case (cnt_reg)
            3'd0: push_byte = pc_reg[7:0];
            3'd1: push_byte = {3'b000, pc_reg[12:8]};
            3'd2: push_byte = index_reg;
            3'd3: push_byte = acc_reg;
            3'd4: push_byte = {3'b111, flags_reg};
            default: push_byte = 8'h00;
        endcase
    end

    always_comb begin
        o_stack       = '0;
        o_stack.addr  = {SP_HIGH_FIX, sp_reg[5:0]};
        if (seq_reg == ST_PUSH) begin
            o_stack.valid = 1'b1;
            o_stack.write = 1'b1;
            o_stack.wdata = push_byte;
        end else if (seq_reg == ST_PULL_ADDR) begin
            o_stack.valid = 1'b1;
            o_stack.addr  = {SP_HIGH_FIX, sp_low_up};
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    logic [2:0] pull_idx;
    assign pull_idx = is_rti_reg ? cnt_reg : cnt_reg + 3'd3;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            seq_reg    <= ST_IDLE;
            cnt_reg    <= 3'd0;
            is_rti_reg <= 1'b0;
        end else begin
            case (seq_reg)
                ST_IDLE: begin
                    cnt_reg <= 3'd0;
                    if (take) begin
                        seq_reg    <= ST_PUSH;
                        is_rti_reg <= 1'b1;
                    end else if (i_req_valid) begin
                        if (i_req.op == OP_CALL || i_req.op == OP_INTR) begin
                            seq_reg    <= ST_PUSH;
                            is_rti_reg <= (i_req.op == OP_INTR);
                        end else if (i_req.op == OP_RET
                                     || i_req.op == OP_RTI) begin
                            seq_reg    <= ST_PULL_ADDR;
                            is_rti_reg <= (i_req.op == OP_RTI);
                        end
                    end
                end
                ST_PUSH: begin
                    cnt_reg <= cnt_reg + 3'd1;
                    seq_reg <= (cnt_reg == push_len - 3'd1) ? ST_IDLE : ST_PUSH;
                end
                ST_PULL_ADDR: seq_reg <= ST_PULL_DATA;
                ST_PULL_DATA: begin
                    cnt_reg <= cnt_reg + 3'd1;
                    seq_reg <= (cnt_reg == (is_rti_reg ? 3'd4 : 3'd1))
                             ? ST_IDLE : ST_PULL_ADDR;
                end
                default: seq_reg <= ST_IDLE;
            endcase
        end
    end

    // pulled bytes come back flags, acc, index, high, low
    always_ff @(posedge i_clk) begin
        if (seq_reg == ST_PULL_DATA) begin
            pull_buf_reg[pull_idx] <= i_stack_rdata;
        end
    end

    // ****************************************
    // stack pointer
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            sp_reg <= SP_RESET;
        end else if (seq_reg == ST_IDLE && i_req_valid && !take
                     && i_req.op == OP_RSP) begin
            sp_reg <= SP_RESET;
        end else if (seq_reg == ST_PUSH) begin
            sp_reg <= {2'b11, sp_reg[5:0] - 6'h01};
        end else if (seq_reg == ST_PULL_ADDR) begin
            sp_reg <= {2'b11, sp_low_up};
        end else if (avs_wr && i_avs_address == OFF_SP) begin
            sp_reg <= {2'b11, i_avs_writedata[5:0]};
        end
    end

    // ****************************************
    // avalon slave: one wait cycle, then answer
    // ****************************************
    assign avs_hit = (i_avs_read | i_avs_write) & ~avs_done_reg;
    assign o_avs_waitrequest = avs_hit;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            avs_done_reg <= 1'b0;
        end else begin
            avs_done_reg <= avs_hit;
        end
    end

    logic avs_wr;
    assign avs_wr = i_avs_write & avs_done_reg & i_avs_byteenable[0];

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_avs_readdata <= UNMAPPED_VAL;
        end else if (i_avs_read & ~avs_done_reg) begin
            case (i_avs_address)
                OFF_ACC:     o_avs_readdata <= {24'h0, acc_reg};
                OFF_INDEX:   o_avs_readdata <= {24'h0, index_reg};
                OFF_PC:      o_avs_readdata <= {19'h0, pc_reg};
                OFF_SP:      o_avs_readdata <= {24'h0, sp_reg};
                OFF_FLAGS:   o_avs_readdata <= {27'h0, flags_reg};
                OFF_PENDING: o_avs_readdata <= {30'h0, tmr_pend, ext_pend};
                default:     o_avs_readdata <= UNMAPPED_VAL;
            endcase
        end
    end

    // ****************************************
    // accumulator and index
    // ****************************************
    logic alu_go;
    assign alu_go = (seq_reg == ST_IDLE) & i_req_valid & ~take;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            acc_reg <= 8'h00;
        end else if (seq_reg == ST_PULL_DATA && is_rti_reg
                     && cnt_reg == 3'd1) begin
            acc_reg <= i_stack_rdata;
        end else if (alu_go && !i_req.dst_index && upd_nz) begin
            acc_reg <= alu_res;
        end else if (avs_wr && i_avs_address == OFF_ACC) begin
            acc_reg <= i_avs_writedata[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            index_reg <= 8'h00;
        end else if (seq_reg == ST_PULL_DATA && is_rti_reg
                     && cnt_reg == 3'd2) begin
            index_reg <= i_stack_rdata;
        end else if (alu_go && i_req.dst_index && upd_nz) begin
            index_reg <= alu_res;
        end else if (avs_wr && i_avs_address == OFF_INDEX) begin
            index_reg <= i_avs_writedata[7:0];
        end
    end

    // ****************************************
    // program counter
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pc_reg <= PC_RESET;
        end else if (seq_reg == ST_PULL_DATA
                     && cnt_reg == (is_rti_reg ? 3'd4 : 3'd1)) begin
            pc_reg <= {pull_buf_reg[3][4:0], i_stack_rdata};
        end else if (i_pc_load) begin
            pc_reg <= i_pc_value;
        end else if (avs_wr && i_avs_address == OFF_PC) begin
            pc_reg <= {i_avs_writedata[12:8] & {5{i_avs_byteenable[1]}},
                       i_avs_writedata[7:0]};
        end
    end

    // ****************************************
    // condition flags
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            flags_reg <= FLAGS_RESET;
        end else if (seq_reg == ST_PULL_DATA && is_rti_reg
                     && cnt_reg == 3'd0) begin
            flags_reg <= i_stack_rdata[4:0];
        end else if (seq_reg == ST_PUSH && cnt_reg == 3'd4) begin
            flags_reg[FLAG_I] <= 1'b1;
        end else if (alu_go) begin
            if (upd_c) flags_reg[FLAG_C] <= alu_c;
            if (upd_h) flags_reg[FLAG_H] <= alu_h;
            if (upd_nz) begin
                flags_reg[FLAG_N] <= alu_res[7];
                flags_reg[FLAG_Z] <= (alu_res == 8'h00);
            end
            if (i_req.op == OP_CLI) flags_reg[FLAG_I] <= 1'b0;
            if (i_req.op == OP_SEI) flags_reg[FLAG_I] <= 1'b1;
        end else if (avs_wr && i_avs_address == OFF_FLAGS) begin
            flags_reg <= i_avs_writedata[4:0];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_push_one;
        seq_reg == ST_PUSH;
    endsequence

    property p_sp_reset;
        @(posedge i_clk) !i_nrst |=> sp_reg == SP_RESET;
    endproperty
    a_sp_reset: assert property (p_sp_reset) else $error("sp not reset");

    property p_push_dec;
        @(posedge i_clk) disable iff (!i_nrst)
        s_push_one |=> sp_reg[5:0] == $past(sp_reg[5:0]) - 6'h01;
    endproperty
    a_push_dec: assert property (p_push_dec) else $error("push no dec");

    property p_stack_addr;
        @(posedge i_clk) disable iff (!i_nrst)
        o_stack.valid |-> o_stack.addr[12:6] == SP_HIGH_FIX;
    endproperty
    a_stack_addr: assert property (p_stack_addr) else $error("bad addr");

    property p_sp_window;
        @(posedge i_clk) disable iff (!i_nrst) sp_reg[7:6] == 2'b11;
    endproperty
    a_sp_window: assert property (p_sp_window) else $error("sp window");

    property p_call_two;
        @(posedge i_clk) disable iff (!i_nrst)
        (seq_reg == ST_IDLE && i_req_valid && !take && i_req.op == OP_CALL)
        |=> s_push_one ##1 s_push_one ##1 seq_reg == ST_IDLE;
    endproperty
    a_call_two: assert property (p_call_two) else $error("call len");

    property p_low_first;
        @(posedge i_clk) disable iff (!i_nrst)
        (s_push_one and cnt_reg == 3'd0) |-> o_stack.wdata == pc_reg[7:0];
    endproperty
    a_low_first: assert property (p_low_first) else $error("order");

    property p_mask_block;
        @(posedge i_clk) disable iff (!i_nrst)
        flags_reg[FLAG_I] |-> !o_irq_take;
    endproperty
    a_mask_block: assert property (p_mask_block) else $error("masked");

    property p_irq_sets_mask;
        @(posedge i_clk) disable iff (!i_nrst)
        o_irq_take |-> ##6 flags_reg[FLAG_I];
    endproperty
    a_irq_sets_mask: assert property (p_irq_sets_mask) else $error("no mask");

    property p_zero_flag;
        @(posedge i_clk) disable iff (!i_nrst)
        (alu_go && upd_nz) |=> flags_reg[FLAG_Z] == ($past(alu_res) == 8'h00);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero");

    property p_half;
        @(posedge i_clk) disable iff (!i_nrst)
        (alu_go && i_req.op == OP_ADD
         && i_req.operand[3:0] == 4'hf && !i_req.dst_index
         && acc_reg[3:0] != 4'h0) |=> flags_reg[FLAG_H];
    endproperty
    a_half: assert property (p_half) else $error("half carry");

endmodule

// file: src/cpu_regs_pkg.sv
// package: constants, types and register map of the cpu register file
//
// Contract
// - an 8-bit accumulator holds operands and arithmetic or data results.
// - an 8-bit index register forms indexed addresses and may hold data.
// - a 13-bit program counter holds the address of the next fetch byte.
// - reset and the reload instruction set the stack pointer to 00ff.
// - the pointer names the next free byte: post-decrement push, pre-increment pull.
// - stack addresses force the upper seven bits to 0000011 above six pointer bits.
// - the stack spans 64 bytes and wraps silently, overwriting old bytes.
// - a subroutine call pushes two bytes and an interrupt pushes five.
// - the return address low byte goes first, high byte next; pulls reverse it.
// - a 5-bit flag register holds four result flags and an interrupt mask.
// - add and add-with-carry set half carry on a carry from bit 3 into bit 4.
// - a set mask blocks timer and external requests, which stay latched.
// - negative and zero flags follow the sign and zero state of a result.
// - carry follows alu carry or borrow, bit tests, shifts and rotates.
package cpu_regs_pkg;

    // ****************************************
    // widths and reset values
    // ****************************************
    localparam int          DATA_W      = 8;
    localparam int          PC_W        = 13;
    localparam int          SP_LOW_W    = 6;
    localparam int          FLAGS_W     = 5;
    localparam logic [7:0]  SP_RESET    = 8'hff;
    localparam logic [6:0]  SP_HIGH_FIX = 7'h03;
    localparam logic [12:0] PC_RESET    = 13'h0000;
    localparam logic [4:0]  FLAGS_RESET = 5'h08;

    // flag bit positions: h i n z c
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_I = 3;
    localparam int FLAG_H = 4;

    // ****************************************
    // avalon register map, byte addresses
    // ****************************************
    localparam int          ADDR_W       = 5;
    localparam logic [4:0]  OFF_ACC      = 5'h00;
    localparam logic [4:0]  OFF_INDEX    = 5'h04;
    localparam logic [4:0]  OFF_PC       = 5'h08;
    localparam logic [4:0]  OFF_SP       = 5'h0c;
    localparam logic [4:0]  OFF_FLAGS    = 5'h10;
    localparam logic [4:0]  OFF_PENDING  = 5'h14;
    localparam logic [31:0] UNMAPPED_VAL = 32'h00000000;

    // ****************************************
    // core operations
    // ****************************************
    typedef enum logic [3:0] {
        OP_NONE,
        OP_ADD,
        OP_ADC,
        OP_SUB,
        OP_AND,
        OP_LOAD,
        OP_SHL,
        OP_ROL,
        OP_BTST,
        OP_CALL,
        OP_INTR,
        OP_RET,
        OP_RTI,
        OP_RSP,
        OP_CLI,
        OP_SEI
    } cpu_op_e;

    typedef struct packed {
        cpu_op_e    op;
        logic       dst_index;
        logic [7:0] operand;
        logic       bit_val;
        logic [12:0] ret_addr;
    } core_req_s;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [12:0] addr;
        logic [7:0]  wdata;
    } stack_bus_s;

endpackage
